// ===== common/cmev_defs.svh
// Contract
// RULE1 - Three channels, each powered by its own enable bit, bits 2-0.
// RULE2 - Enable bit 0 means powerdown, 1 means active; all clear after reset.
// RULE3 - Each channel has an event flag, bits 2-0, set on a selected edge.
// RULE4 - Polarity 0 flags falling edges only, polarity 1 rising edges only.
// RULE5 - Reading the event flag register clears all three flags.
// RULE6 - Powering a channel down clears its pending event flag.
// RULE7 - Bits 6-4 of all four registers read live levels; writes ignored.
// RULE8 - A powered-down channel holds its last live level.
// RULE9 - Live levels are readable regardless of the mask setting.
// RULE10 - Software writes zero to bits 7 and 3; they read as zero.
// RULE11 - All three polarity bits are set after reset.
// RULE12 - Each channel has a mask bit; masked transitions are not latched.
// RULE13 - Software changes polarity only while masked or powered down.
// RULE14 - Comparator outputs pass a two-stage synchroniser before use.
// RULE15 - An edge in the same cycle as a clearing read keeps its flag.
`ifndef CMEV_DEFS_SVH
`define CMEV_DEFS_SVH

// ****************************************
// Register indices, byte address is four times the index
// ****************************************
`define CMEV_IDX_POWER 7'h4c
`define CMEV_IDX_EDGE 7'h4d
`define CMEV_IDX_EVENT 7'h4e
`define CMEV_IDX_MASK 7'h4f

// ****************************************
// Field positions and reset values
// ****************************************
`define CMEV_NUM_CH 3
`define CMEV_FLD_CTL_LSB 0
`define CMEV_FLD_LIVE_LSB 4
`define CMEV_RST_POWER 3'h0
`define CMEV_RST_EDGE 3'h7
`define CMEV_RST_EVENT 3'h0
`define CMEV_RST_MASK 3'h0
`define CMEV_RST_LIVE 3'h0

`endif

// ===== common/cmev_pkg.sv
package cmev_pkg;

    typedef logic [2:0] cmev_ch_t;

    typedef struct packed {
        cmev_ch_t stage1;
        cmev_ch_t stage2;
    } cmev_sync_state_s;

    typedef struct packed {
        logic live;
    } cmev_chan_state_s;

    typedef struct packed {
        cmev_ch_t power;
        cmev_ch_t edge_sel;
        cmev_ch_t event_flag;
        cmev_ch_t mask;
        logic ack;
        logic [31:0] rdata;
    } cmev_top_state_s;

endpackage

// ===== src/cmev_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmev_defs.svh"

module cmev_sync
    import cmev_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire cmev_ch_t async_in,
    output cmev_ch_t sync_out
);

    cmev_sync_state_s state_ff;
    cmev_sync_state_s nxt_state;

    // ****************************************
    // Two stages; the first is read by the second only
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        if (ce) begin
            nxt_state.stage1 = async_in; // [RULE14]
            nxt_state.stage2 = state_ff.stage1; // [RULE14]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stage2;

endmodule // cmev_sync
`default_nettype wire

// ===== src/cmev_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmev_defs.svh"

module cmev_chan
    import cmev_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic level,
    input wire logic channel_power_enable,
    input wire logic edge_polarity_select,
    input wire logic mask_enable,
    output logic live_output_status,
    output logic hit
);

    cmev_chan_state_s state_ff;
    cmev_chan_state_s nxt_state;
    logic rise;
    logic fall;

    // ****************************************
    // Live level tracking and edge qualification
    // ****************************************
    assign rise = level & ~state_ff.live;
    assign fall = ~level & state_ff.live;
    // Edge counts only while powered and unmasked
    assign hit = ce & channel_power_enable & mask_enable & // [RULE12]
                 (edge_polarity_select ? rise : fall); // [RULE3] [RULE4]

    always_comb begin
        nxt_state = state_ff;
        if (ce && channel_power_enable) begin
            nxt_state.live = level; // [RULE8]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign live_output_status = state_ff.live;

endmodule // cmev_chan
`default_nettype wire

// ===== src/cmev_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmev_defs.svh"

module cmev_top
    import cmev_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire cmev_ch_t comparator_out,
    input wire logic [8:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic is_reg(input logic [8:0] addr, input logic [6:0] idx);
        is_reg = (addr[8:2] == idx);
    endfunction

    // Byte image: reserved bits 7 and 3 read as zero
    function automatic logic [31:0] reg_word(input cmev_ch_t live, input cmev_ch_t ctl);
        reg_word = {24'h0, 1'b0, live, 1'b0, ctl}; // [RULE7] [RULE10]
    endfunction

    cmev_top_state_s state_ff;
    cmev_top_state_s nxt_state;
    cmev_ch_t sync_level;
    cmev_ch_t live_output_status;
    cmev_ch_t hit;
    cmev_ch_t clr;
    logic req;
    logic first;
    logic lane0;

    // ****************************************
    // Synchroniser and per-channel logic
    // ****************************************
    cmev_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .async_in(comparator_out),
        .sync_out(sync_level)
    );

    generate
        for (genvar i = 0; i < `CMEV_NUM_CH; i++) begin : g_chan
            cmev_chan u_chan (
                .clk(clk),
                .rst_b(rst_b),
                .ce(ce),
                .level(sync_level[i]),
                .channel_power_enable(state_ff.power[i]), // [RULE1]
                .edge_polarity_select(state_ff.edge_sel[i]),
                .mask_enable(state_ff.mask[i]),
                .live_output_status(live_output_status[i]),
                .hit(hit[i])
            );
        end
    endgenerate

    // ****************************************
    // Avalon slave: one wait cycle, then acknowledge
    // ****************************************
    assign req = read | write;
    assign first = ce & req & ~state_ff.ack;
    assign lane0 = byteenable[0];
    assign waitrequest = req & ~state_ff.ack;

    always_comb begin
        nxt_state = state_ff;
        clr = 3'h0;
        if (ce) begin
            nxt_state.ack = req & ~state_ff.ack;
            // Read data and read side effect at the first edge of the access
            if (first && read) begin
                if (is_reg(address, `CMEV_IDX_POWER)) begin
                    nxt_state.rdata = reg_word(live_output_status, state_ff.power); // [RULE9]
                end else if (is_reg(address, `CMEV_IDX_EDGE)) begin
                    nxt_state.rdata = reg_word(live_output_status, state_ff.edge_sel);
                end else if (is_reg(address, `CMEV_IDX_EVENT)) begin
                    nxt_state.rdata = reg_word(live_output_status, state_ff.event_flag);
                    clr = 3'h7; // [RULE5]
                end else if (is_reg(address, `CMEV_IDX_MASK)) begin
                    nxt_state.rdata = reg_word(live_output_status, state_ff.mask);
                end else begin
                    nxt_state.rdata = 32'h0;
                end
            end
            // Writes take effect at the acknowledging edge; bits 7-4 and 3 dropped
            if (state_ff.ack && write && lane0) begin
                if (is_reg(address, `CMEV_IDX_POWER)) begin
                    nxt_state.power = writedata[2:0]; // [RULE1] [RULE2]
                end
                if (is_reg(address, `CMEV_IDX_EDGE)) begin
                    nxt_state.edge_sel = writedata[2:0]; // [RULE4]
                end
                if (is_reg(address, `CMEV_IDX_MASK)) begin
                    nxt_state.mask = writedata[2:0]; // [RULE12]
                end
                if (is_reg(address, `CMEV_IDX_EVENT)) begin
                    clr = clr | writedata[2:0];
                end
            end
            // New edges win over any clear; powered-down channels drop flags
            nxt_state.event_flag = ((state_ff.event_flag & ~clr) | hit) // [RULE3] [RULE15]
                                   & state_ff.power; // [RULE6]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff.power <= `CMEV_RST_POWER; // [RULE2]
            state_ff.edge_sel <= `CMEV_RST_EDGE; // [RULE11]
            state_ff.event_flag <= `CMEV_RST_EVENT;
            state_ff.mask <= `CMEV_RST_MASK;
            state_ff.ack <= 1'b0;
            state_ff.rdata <= 32'h0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign readdata = state_ff.rdata;
    assign irq = |(state_ff.event_flag & state_ff.mask);

endmodule // cmev_top
`default_nettype wire

// ===== tb/cmev_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cmev_top_assertions
    import cmev_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire cmev_ch_t comparator_out,
    input wire logic [8:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    cmev_ch_t cmp_ff;
    logic [3:0] calm_ff;
    // Cycles since the comparator levels last moved
    always_ff @(posedge clk) begin
        cmp_ff <= comparator_out;
        if (!rst_b || comparator_out != cmp_ff) begin
            calm_ff <= 4'h0;
        end else if (calm_ff != 4'hf) begin
            calm_ff <= calm_ff + 4'h1;
        end
    end
    property p_req_wait;
        $rose(read || write) |-> waitrequest;
    endproperty
    a_req_wait: assert property (p_req_wait) else $error("no wait on new request");
    property p_ack;
        (read || write) && waitrequest && ce |=> !waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_unmapped;
        read && !waitrequest && !(address[8:2] inside {[7'h4c:7'h4f]}) |-> readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rsv;
        read && !waitrequest |-> readdata[31:7] == 25'h0 && !readdata[3];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_clear;
        read && !waitrequest && address[8:2] == 7'h4e && calm_ff >= 4'h4 |-> !irq;
    endproperty
    a_clear: assert property (p_clear) else $error("flags kept after read");
    property p_sync;
        $rose(irq) && !$past(write) && !$past(write, 2) && $past(ce) && $past(ce, 2)
            && $past(ce, 3) && $past(ce, 4) |-> calm_ff == 4'h2;
    endproperty
    a_sync: assert property (p_sync) else $error("event latency wrong");
    property p_pd;
        write && !waitrequest && address[8:2] == 7'h4c && byteenable[0]
            && writedata[2:0] == 3'h0 |-> ##2 !irq;
    endproperty
    a_pd: assert property (p_pd) else $error("flag kept in powerdown");
    property p_mask;
        write && !waitrequest && address[8:2] == 7'h4f && byteenable[0]
            && writedata[2:0] == 3'h0 |=> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq while all masked");
    c_irq: cover property ($rose(irq));
    c_flag: cover property (read && !waitrequest && address[8:2] == 7'h4e && readdata[2:0] != 3'h0);
    c_wr: cover property (write && !waitrequest);
endmodule // cmev_top_assertions
bind cmev_top cmev_top_assertions u_chk (.clk, .rst_b, .ce, .comparator_out, .address, .read,
    .write, .byteenable, .writedata, .readdata, .waitrequest, .irq);
`default_nettype wire

// ===== tb/cmev_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmev_cmp_model
    import cmev_pkg::*;
(
    input wire cmev_ch_t level_req,
    output var cmev_ch_t comparator_out
);
    // Outputs move off the clock grid, as analogue edges do
    initial comparator_out = 3'h0;
    always @(level_req) begin
        comparator_out <= #7 level_req;
    end
endmodule // cmev_cmp_model
`default_nettype wire

// ===== tb/cmev_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cmev_top_tb_top;
    import cmev_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [8:0] address = 9'h0;
    logic [31:0] writedata = 32'h0;
    logic ce = 1'b1;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    cmev_ch_t level_req = 3'h0;
    cmev_ch_t comparator_out;
    int num_errors = 0;
    int checked = 0;
    always #20 clk = ~clk;
    cmev_cmp_model u_cmp (.level_req(level_req), .comparator_out(comparator_out));
    cmev_top DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .comparator_out(comparator_out),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clk);
        read <= ~wr;
        write <= wr;
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rd(input string what, input logic [6:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(what, q, {24'h0, exp});
    endtask
    task automatic lv(input cmev_ch_t v);
        level_req <= v;
        repeat (5) @(posedge clk);
    endtask
    task automatic t_reset();
        rd("power", 7'h4c, 8'h00);
        rd("edge", 7'h4d, 8'h07);
        rd("flags", 7'h4e, 8'h00);
        rd("mask", 7'h4f, 8'h00);
        wr(7'h4b, 8'h07);
        rd("unmapped", 7'h4b, 8'h00);
    endtask
    task automatic t_ro();
        wr(7'h4c, 8'h77);
        rd("power ro", 7'h4c, 8'h07);
        wr(7'h4d, 8'h75);
        rd("edge ro", 7'h4d, 8'h05);
        byteenable <= 4'h0;
        wr(7'h4f, 8'h07);
        byteenable <= 4'h1;
        rd("lane off", 7'h4f, 8'h00);
        wr(7'h4f, 8'h07);
    endtask
    task automatic t_edge();
        lv(3'h3);
        chk("irq up", {31'h0, irq}, 32'h1);
        rd("rise", 7'h4e, 8'h31);
        rd("cleared", 7'h4e, 8'h30);
        lv(3'h0);
        rd("fall", 7'h4e, 8'h02);
    endtask
    task automatic t_mask();
        wr(7'h4f, 8'h00);
        lv(3'h5);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rd("poll", 7'h4f, 8'h50);
        rd("not latched", 7'h4e, 8'h50);
    endtask
    task automatic t_pd();
        wr(7'h4f, 8'h07);
        lv(3'h7);
        lv(3'h5);
        chk("irq pend", {31'h0, irq}, 32'h1);
        wr(7'h4c, 8'h00);
        lv(3'h7);
        rd("pd flags", 7'h4e, 8'h50);
        rd("held", 7'h4c, 8'h50);
    endtask
    // Edge lands on the clearing edge of the first read
    task automatic t_race();
        wr(7'h4c, 8'h07);
        level_req <= 3'h5;
        @(posedge clk);
        rd("race read", 7'h4e, 8'h70);
        rd("race kept", 7'h4e, 8'h52);
    endtask
    task automatic t_freeze();
        lv(3'h7);
        ce <= 1'b0;
        level_req <= 3'h5;
        repeat (6) @(posedge clk);
        chk("irq frozen", {31'h0, irq}, 32'h0);
        ce <= 1'b1;
        repeat (5) @(posedge clk);
        chk("irq thawed", {31'h0, irq}, 32'h1);
        rd("thawed", 7'h4e, 8'h52);
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_ro();
        t_edge();
        t_mask();
        t_pd();
        t_race();
        t_freeze();
        stop_test();
    end
    initial begin
        repeat (1000) @(posedge clk);
        num_errors++;
        stop_test();
    end
endmodule // cmev_top_tb_top
`default_nettype wire
